/* rtl/pfs_defs.vh */
// Purpose: Shared constants of the port pin and function steering block.
// Assumes: Byte addresses on the register bus, one 32-bit word per register.
// Notes: Registers hold 8 bits (port A registers 6) in the low byte; upper bits read as zero.
`ifndef PFS_DEFS_VH
`define PFS_DEFS_VH

// ----------------------------------------------------------------
// Bus geometry
// ----------------------------------------------------------------
`define PFS_ADDR_W 6
`define PFS_DATA_W 32

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PFS_OFF_PA_LEVEL 6'h00
`define PFS_OFF_PA_DIR 6'h04
`define PFS_OFF_PA_LATCH 6'h08
`define PFS_OFF_PA_ANALOG 6'h0C
`define PFS_OFF_PC_LEVEL 6'h10
`define PFS_OFF_PC_DIR 6'h14
`define PFS_OFF_PC_LATCH 6'h18
`define PFS_OFF_PC_ANALOG 6'h1C
`define PFS_OFF_STEER 6'h20

// ----------------------------------------------------------------
// Steering register fields
// ----------------------------------------------------------------
`define PFS_STEER_REFCLK 7
`define PFS_STEER_SDO 6
`define PFS_STEER_SS 5
`define PFS_STEER_TGATE 3
`define PFS_STEER_SECOND_PWM_OUTPUT 2
`define PFS_STEER_MASK_SMALL 8'hEC
`define PFS_STEER_MASK_LARGE 8'hA8
`define PFS_STEER_RESET 8'h00

// ----------------------------------------------------------------
// Port A layout and port A and C reset values
// ----------------------------------------------------------------
`define PFS_PA_PRESENT 6'h3B
`define PFS_PA_OUTPUT 6'h30
`define PFS_PA_ANALOG 6'h10
`define PFS_PA_DIR_RESET 6'h3F
`define PFS_PA_LATCH_RESET 6'h00
`define PFS_PA_ANALOG_RESET 6'h10
`define PFS_PC_DIR_RESET 8'hFF
`define PFS_PC_LATCH_RESET 8'h00

`endif

/* rtl/pfs_port_pins.v */
// Purpose: Port A and port C pin logic with peripheral function steering.
// Assumes: Pin inputs are asynchronous and pass a two-stage synchroniser.
// Notes: Register access over Avalon-MM, one wait cycle per transfer.
//
// The Avalon-MM slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "pfs_defs.vh"

module pfs_port_pins #(
	parameter SMALL_VARIANT = 1,
	parameter [7:0] PC_ANALOG_MASK = 8'h0F,
	parameter [7:0] PC_ANALOG_RESET = 8'h0F
) (
	input wire clk,
	input wire reset_n,
	input wire [`PFS_ADDR_W-1:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [`PFS_DATA_W-1:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [`PFS_DATA_W-1:0] avs_readdata,
	output reg avs_waitrequest,
	input wire [5:0] pa_in,
	output reg [5:0] pa_out,
	output reg [5:0] pa_oe_n,
	input wire [7:0] pc_in,
	output reg [7:0] pc_out,
	output reg [7:0] pc_oe_n,
	input wire clkout_en,
	input wire clkout_val,
	input wire sosc_out_en,
	input wire sosc_out_val,
	input wire refclk_en,
	input wire reference_clock_output,
	input wire sdo_en,
	input wire serial_data_out,
	input wire pwm_two_en,
	input wire second_pwm_output,
	output reg slave_select_n,
	output reg timer_gate_input,
	output reg [5:0] pa_digital_in,
	output reg [7:0] pc_digital_in
);

	// ----------------------------------------------------------------
	// Bus handshake states
	// ----------------------------------------------------------------
	localparam [1:0] ST_IDLE = 2'b01;
	localparam [1:0] ST_ACK = 2'b10;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Two-level pick: first enabled source wins, else the fallback
	function pick2;
		input en_a;
		input val_a;
		input en_b;
		input val_b;
		input fallback;
		begin
			if (en_a) begin
				pick2 = val_a;
			end else if (en_b) begin
				pick2 = val_b;
			end else begin
				pick2 = fallback;
			end
		end
	endfunction

	function [31:0] word8;
		input [7:0] val;
		begin
			word8 = {24'h00_0000, val};
		end
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	reg [1:0] state;
	reg [5:0] pa_sync1;
	reg [5:0] pa_sync2;
	reg [7:0] pc_sync1;
	reg [7:0] pc_sync2;
	reg [5:0] pa_dir;
	reg [5:0] pa_latch;
	reg [5:0] pa_analog;
	reg [7:0] pc_dir;
	reg [7:0] pc_latch;
	reg [7:0] pc_analog;
	reg [7:0] steer;
	reg [31:0] next_readdata;
	reg [5:0] next_pa_out;
	reg [7:0] next_pc_out;
	reg next_ss_n;
	reg next_tgate;

	wire [7:0] steer_mask;
	wire sel_refclk;
	wire sel_sdo;
	wire sel_ss;
	wire sel_tgate;
	wire sel_second_pwm_output;
	wire [5:0] pa_level;
	wire [7:0] pc_level;
	wire [5:0] pa_dir_view;
	wire bus_commit;
	wire wr_lane;

	assign steer_mask = (SMALL_VARIANT != 0) ? `PFS_STEER_MASK_SMALL : `PFS_STEER_MASK_LARGE;
	assign sel_refclk = steer[`PFS_STEER_REFCLK];
	assign sel_sdo = steer[`PFS_STEER_SDO];
	assign sel_ss = steer[`PFS_STEER_SS];
	assign sel_tgate = steer[`PFS_STEER_TGATE];
	assign sel_second_pwm_output = steer[`PFS_STEER_SECOND_PWM_OUTPUT];
	assign bus_commit = avs_write & state[1];
	assign wr_lane = avs_byteenable[0];

	// ----------------------------------------------------------------
	// Pin input path
	// ----------------------------------------------------------------
	// two-stage synchroniser
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pa_sync1 <= 6'h00;
			pa_sync2 <= 6'h00;
			pc_sync1 <= 8'h00;
			pc_sync2 <= 8'h00;
		end else begin
			pa_sync1 <= pa_in;
			pa_sync2 <= pa_sync1;
			pc_sync1 <= pc_in;
			pc_sync2 <= pc_sync1;
		end
	end

	assign pa_level = pa_sync2 & ~pa_analog & `PFS_PA_PRESENT;
	assign pc_level = pc_sync2 & ~pc_analog;

	assign pa_dir_view = (pa_dir & `PFS_PA_OUTPUT) | (`PFS_PA_PRESENT & ~`PFS_PA_OUTPUT);

	// ----------------------------------------------------------------
	// Register read mux
	// ----------------------------------------------------------------
	// latch reads stored value, level reads pins
	always @* begin
		next_readdata = 32'h0000_0000;
		case (avs_address)
			`PFS_OFF_PA_LEVEL: begin
				next_readdata = word8({2'b00, pa_level});
			end
			`PFS_OFF_PA_DIR: begin
				next_readdata = word8({2'b00, pa_dir_view});
			end
			`PFS_OFF_PA_LATCH: begin
				next_readdata = word8({2'b00, pa_latch});
			end
			`PFS_OFF_PA_ANALOG: begin
				next_readdata = word8({2'b00, pa_analog});
			end
			`PFS_OFF_PC_LEVEL: begin
				next_readdata = word8(pc_level);
			end
			`PFS_OFF_PC_DIR: begin
				next_readdata = word8(pc_dir);
			end
			`PFS_OFF_PC_LATCH: begin
				next_readdata = word8(pc_latch);
			end
			`PFS_OFF_PC_ANALOG: begin
				next_readdata = word8(pc_analog);
			end
			`PFS_OFF_STEER: begin
				next_readdata = word8(steer);
			end
			default: begin
				next_readdata = 32'h0000_0000;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Bus handshake
	// ----------------------------------------------------------------
	// Answer one cycle after the request so read data comes from a flop
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= ST_IDLE;
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
		end else begin
			case (state)
				ST_IDLE: begin
					if (avs_read || avs_write) begin
						state <= ST_ACK;
						avs_waitrequest <= 1'b0;
						avs_readdata <= avs_read ? next_readdata : 32'h0000_0000;
					end
				end
				ST_ACK: begin
					state <= ST_IDLE;
					avs_waitrequest <= 1'b1;
				end
				default: begin
					state <= ST_IDLE;
					avs_waitrequest <= 1'b1;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Register writes
	// ----------------------------------------------------------------
	// per-port register storage
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pa_dir <= `PFS_PA_DIR_RESET;
			pc_dir <= `PFS_PC_DIR_RESET;
			pa_latch <= `PFS_PA_LATCH_RESET;
			pc_latch <= `PFS_PC_LATCH_RESET;
			pa_analog <= `PFS_PA_ANALOG_RESET;
			pc_analog <= PC_ANALOG_RESET & PC_ANALOG_MASK;
			steer <= `PFS_STEER_RESET;
		end else if (bus_commit) begin
			case (avs_address)
				`PFS_OFF_PA_LEVEL, `PFS_OFF_PA_LATCH: begin
					// both offsets land in the latch
					pa_latch <= (wr_lane ? avs_writedata[5:0] : pa_level) & `PFS_PA_OUTPUT;
				end
				`PFS_OFF_PC_LEVEL, `PFS_OFF_PC_LATCH: begin
					// both offsets land in the latch
					pc_latch <= wr_lane ? avs_writedata[7:0] : pc_level;
				end
				`PFS_OFF_PA_DIR: begin
					if (wr_lane) begin
						pa_dir <= avs_writedata[5:0] | ~`PFS_PA_OUTPUT;
					end
				end
				`PFS_OFF_PC_DIR: begin
					if (wr_lane) begin
						pc_dir <= avs_writedata[7:0];
					end
				end
				`PFS_OFF_PA_ANALOG: begin
					if (wr_lane) begin
						pa_analog <= avs_writedata[5:0] & `PFS_PA_ANALOG;
					end
				end
				`PFS_OFF_PC_ANALOG: begin
					if (wr_lane) begin
						pc_analog <= avs_writedata[7:0] & PC_ANALOG_MASK;
					end
				end
				`PFS_OFF_STEER: begin
					// steering write touches no direction bit
					if (wr_lane) begin
						steer <= avs_writedata[7:0] & steer_mask;
					end
				end
				default: begin
					steer <= steer;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Output function steering
	// ----------------------------------------------------------------
	always @* begin
		next_pa_out = pa_latch;
		next_pc_out = pc_latch;
		// clock out, oscillator, refclk, serial out, latch
		// refclk on A4 when select is zero
		// serial out on A4 when select is one
		next_pa_out[4] = pick2(clkout_en, clkout_val, sosc_out_en, sosc_out_val,
			pick2(refclk_en & ~sel_refclk, reference_clock_output,
				sdo_en & sel_sdo & (SMALL_VARIANT != 0), serial_data_out, pa_latch[4]));
		// second PWM on A5 when select is one
		next_pa_out[5] = pick2(pwm_two_en & sel_second_pwm_output & (SMALL_VARIANT != 0),
			second_pwm_output, 1'b0, 1'b0, pa_latch[5]);
		// serial out on C2 when select is zero
		next_pc_out[2] = pick2(sdo_en & ~(sel_sdo & (SMALL_VARIANT != 0)),
			serial_data_out, 1'b0, 1'b0, pc_latch[2]);
		// refclk on C3 when select is one
		// second PWM on C3 when select is zero
		next_pc_out[3] = pick2(refclk_en & sel_refclk, reference_clock_output,
			pwm_two_en & ~(sel_second_pwm_output & (SMALL_VARIANT != 0)), second_pwm_output, pc_latch[3]);
	end

	// ----------------------------------------------------------------
	// Peripheral input steering
	// ----------------------------------------------------------------
	always @* begin
		// slave select from A3 or port C
		if (sel_ss) begin
			next_ss_n = pa_level[3];
		end else if (SMALL_VARIANT != 0) begin
			next_ss_n = pc_level[3];
		end else begin
			next_ss_n = pc_level[6];
		end
		// timer gate from A3 or A4
		next_tgate = sel_tgate ? pa_level[3] : pa_level[4];
	end

	// ----------------------------------------------------------------
	// Registered pin and peripheral outputs
	// ----------------------------------------------------------------
	// only the selected pin changes; others keep latch data
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pa_out <= 6'h00;
			pa_oe_n <= 6'h3F;
			pc_out <= 8'h00;
			pc_oe_n <= 8'hFF;
			slave_select_n <= 1'b1;
			timer_gate_input <= 1'b0;
			pa_digital_in <= 6'h00;
			pc_digital_in <= 8'h00;
		end else begin
			// a peripheral replaces the latch as pin source
			pa_out <= next_pa_out & `PFS_PA_OUTPUT;
			pc_out <= next_pc_out;
			pa_oe_n <= pa_dir | ~`PFS_PA_OUTPUT;
			pc_oe_n <= pc_dir;
			slave_select_n <= next_ss_n;
			timer_gate_input <= next_tgate;
			pa_digital_in <= pa_level;
			pc_digital_in <= pc_level;
		end
	end

endmodule // pfs_port_pins

/* verif/pfs_pin_model.sv */
// Purpose: Pad model that resolves each pin from its driver and the outside level.
// Assumes: The bench always drives the outside levels.
// Notes: A pad whose driver is on reads back the driven value.
`timescale 1ns/1ps
module pfs_pin_model (
	input wire [5:0] pa_out,
	input wire [5:0] pa_oe_n,
	input wire [7:0] pc_out,
	input wire [7:0] pc_oe_n,
	input wire [5:0] pa_ext,
	input wire [7:0] pc_ext,
	output wire [5:0] pa_in,
	output wire [7:0] pc_in
);
// ------------------------------------------------------------
// Pad resolution
// ------------------------------------------------------------
// driver wins pad
assign pa_in = (~pa_oe_n & pa_out) | (pa_oe_n & pa_ext);
assign pc_in = (~pc_oe_n & pc_out) | (pc_oe_n & pc_ext);
endmodule // pfs_pin_model

/* verif/pfs_port_pins_sva.sv */
// Purpose: Port-level checks of the pin and steering block.
// Assumes: Small variant, steering shadowed from accepted bus writes.
// Notes: Bound to every instance of the block.
`timescale 1ns/1ps
`include "pfs_defs.vh"
module pfs_port_pins_sva (
	input wire clk,
	input wire reset_n,
	input wire [5:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	input wire [31:0] avs_readdata,
	input wire avs_waitrequest,
	input wire [5:0] pa_in,
	input wire [5:0] pa_out,
	input wire [5:0] pa_oe_n,
	input wire [7:0] pc_out,
	input wire [7:0] pc_oe_n,
	input wire refclk_en,
	input wire reference_clock_output,
	input wire sdo_en,
	input wire serial_data_out,
	input wire pwm_two_en,
	input wire second_pwm_output,
	input wire slave_select_n,
	input wire timer_gate_input
);
default clocking @(posedge clk); endclocking
default disable iff (!reset_n);
// ------------------------------------------------------------
// Steering shadow
// ------------------------------------------------------------
wire acc = avs_write && !avs_waitrequest && avs_byteenable[0];
wire pcdir_wr = acc && (avs_address == `PFS_OFF_PC_DIR);
reg [7:0] steer;
always @(posedge clk or negedge reset_n) begin
	if (!reset_n)
		steer <= 8'h00;
	else if (acc && avs_address == `PFS_OFF_STEER)
		steer <= avs_writedata[7:0] & `PFS_STEER_MASK_SMALL;
end
property p_wait_one;
	(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
endproperty
a_wait_one: assert property (p_wait_one)
	else $error("no answer one cycle after request");
property p_upper_zero;
	avs_readdata[31:8] == 24'h00_0000;
endproperty
a_upper_zero: assert property (p_upper_zero)
	else $error("read data upper bits set");
property p_input_only;
	pa_oe_n[3:0] == 4'hF && pa_out[3:0] == 4'h0;
endproperty
a_input_only: assert property (p_input_only)
	else $error("input-only pin driven");
property p_oe_reset;
	$rose(reset_n) |-> pa_oe_n == 6'h3F && pc_oe_n == 8'hFF && slave_select_n;
endproperty
a_oe_reset: assert property (p_oe_reset)
	else $error("pins not inputs after reset");
property p_dir_hold;
	!$stable(pc_oe_n) |-> $past(pcdir_wr) || $past(pcdir_wr, 2);
endproperty
a_dir_hold: assert property (p_dir_hold)
	else $error("port C driver changed without direction write");
property p_c3_ref;
	refclk_en && steer[7] |=> pc_out[3] == $past(reference_clock_output);
endproperty
a_c3_ref: assert property (p_c3_ref)
	else $error("reference clock missing on C3");
property p_c2_sdo;
	sdo_en && !steer[6] |=> pc_out[2] == $past(serial_data_out);
endproperty
a_c2_sdo: assert property (p_c2_sdo)
	else $error("serial out missing on C2");
property p_a5_pwm;
	pwm_two_en && steer[2] |=> pa_out[5] == $past(second_pwm_output);
endproperty
a_a5_pwm: assert property (p_a5_pwm)
	else $error("second pwm missing on A5");
property p_tgate;
	steer[3] && $past(steer[3]) |-> timer_gate_input == $past(pa_in[3], 3);
endproperty
a_tgate: assert property (p_tgate)
	else $error("timer gate not taken from A3");
endmodule // pfs_port_pins_sva
bind pfs_port_pins pfs_port_pins_sva chk_i (.*);

/* verif/tb_top.sv */
// Purpose: Register and pin tests of the pin and steering block.
// Assumes: Small variant with default parameters.
// Notes: Reads wait four cycles so pin levels pass the synchroniser.
`timescale 1ns/1ps
`include "pfs_defs.vh"
module tb_top;
reg clk = 1'b0;
reg reset_n = 1'b0;
reg [5:0] avs_address = 6'h00;
reg avs_read = 1'b0;
reg avs_write = 1'b0;
reg [31:0] avs_writedata = 32'h0000_0000;
reg [3:0] avs_byteenable = 4'h0;
wire [31:0] avs_readdata;
wire avs_waitrequest;
wire [5:0] pa_in, pa_out, pa_oe_n, pa_digital_in;
wire [7:0] pc_in, pc_out, pc_oe_n, pc_digital_in;
wire slave_select_n, timer_gate_input;
reg [5:0] pa_ext = 6'h3B;
reg [7:0] pc_ext = 8'h00;
reg clkout_en = 1'b0, clkout_val = 1'b0, sosc_out_en = 1'b0, sosc_out_val = 1'b0;
reg refclk_en = 1'b0, reference_clock_output = 1'b0, sdo_en = 1'b0, serial_data_out = 1'b0;
reg pwm_two_en = 1'b0, second_pwm_output = 1'b0;
integer miscompares = 0;
integer check_count = 0;
integer s;
reg [7:0] q;
pfs_port_pins dut (.*);
pfs_pin_model pins (.*);
always #2.5 clk = ~clk;
// ------------------------------------------------------------
// Bus and compare tasks
// ------------------------------------------------------------
task report_and_stop;
	$display("Checks %0d mismatches %0d", check_count, miscompares);
	if (miscompares == 0 && check_count > 0)
		$display("All tests passed");
	else
		$display("Some tests failed");
	$finish;
endtask
task chk(input [7:0] got, input [7:0] exp);
	check_count = check_count + 1;
	if (got !== exp) begin
		miscompares = miscompares + 1;
		$display("Error at %0t: got %h expected %h", $time, got, exp);
	end
endtask
task bus(input w, input [5:0] a, input [7:0] d, input b);
	avs_address <= a;
	avs_writedata <= {24'h00_0000, d};
	avs_byteenable <= {3'b000, b};
	avs_write <= w;
	avs_read <= !w;
	@(posedge clk);
	// Hold until answered; only the watchdog ends a hang
	while (avs_waitrequest !== 1'b0)
		@(posedge clk);
	q = avs_readdata[7:0];
	avs_write <= 1'b0;
	avs_read <= 1'b0;
	@(posedge clk);
endtask
task rchk(input [5:0] a, input [7:0] e, input [7:0] m);
	repeat (4) @(posedge clk);
	bus(1'b0, a, 8'h00, 1'b1);
	chk(q & m, e);
endtask
// ------------------------------------------------------------
// Tests
// ------------------------------------------------------------
initial begin
	repeat (16) @(posedge clk);
	reset_n <= 1'b1;
	@(posedge clk);
	rchk(`PFS_OFF_PA_DIR, 8'h3B, 8'h3B);
	rchk(`PFS_OFF_PC_DIR, 8'hFF, 8'hFF);
	rchk(`PFS_OFF_STEER, 8'h00, 8'hFF);
	rchk(`PFS_OFF_PA_ANALOG, 8'h10, 8'hFF);
	rchk(`PFS_OFF_PC_ANALOG, 8'h0F, 8'hFF);
	rchk(6'h3C, 8'h00, 8'hFF);
	rchk(`PFS_OFF_PA_LEVEL, 8'h2B, 8'h3B);
	chk({2'b00, pa_digital_in & 6'h3B}, 8'h2B);
	$display("Test reset values done");
	bus(1'b1, `PFS_OFF_PA_ANALOG, 8'h00, 1'b1);
	rchk(`PFS_OFF_PA_LEVEL, 8'h3B, 8'h3B);
	bus(1'b1, `PFS_OFF_PA_LATCH, 8'h00, 1'b0);
	rchk(`PFS_OFF_PA_LATCH, 8'h30, 8'hFF);
	bus(1'b1, `PFS_OFF_PA_DIR, 8'h00, 1'b1);
	rchk(`PFS_OFF_PA_DIR, 8'h0B, 8'h3B);
	bus(1'b1, `PFS_OFF_PA_LEVEL, 8'h10, 1'b1);
	rchk(`PFS_OFF_PA_LATCH, 8'h10, 8'hFF);
	rchk(`PFS_OFF_PA_LEVEL, 8'h1B, 8'h3B);
	chk({2'b00, pa_oe_n}, 8'h0F);
	chk({2'b00, pa_out}, 8'h10);
	bus(1'b1, `PFS_OFF_PA_DIR, 8'h30, 1'b1);
	bus(1'b1, `PFS_OFF_PC_DIR, 8'h0F, 1'b1);
	repeat (4) @(posedge clk);
	chk(pc_oe_n, 8'h0F);
	chk({2'b00, pa_oe_n}, 8'h3F);
	$display("Test port A done");
	bus(1'b1, `PFS_OFF_PC_DIR, 8'hFF, 1'b1);
	bus(1'b1, `PFS_OFF_PC_ANALOG, 8'h00, 1'b1);
	bus(1'b1, `PFS_OFF_PC_LATCH, 8'hFF, 1'b1);
	bus(1'b1, `PFS_OFF_PA_LATCH, 8'h30, 1'b1);
	pa_ext <= 6'h08;
	refclk_en <= 1'b1;
	reference_clock_output <= 1'b1;
	sdo_en <= 1'b1;
	pwm_two_en <= 1'b1;
	// Unselected pins keep the latch value of one
	for (s = 0; s < 2; s = s + 1) begin
		bus(1'b1, `PFS_OFF_STEER, s ? 8'hFF : 8'h00, 1'b1);
		repeat (4) @(posedge clk);
		q = {2'b00, pc_out[3], pc_out[2], pa_out[4], pa_out[5], slave_select_n, timer_gate_input};
		chk(q, s ? 8'h33 : 8'h0C);
	end
	rchk(`PFS_OFF_STEER, 8'hEC, 8'hFF);
	rchk(`PFS_OFF_PC_DIR, 8'hFF, 8'hFF);
	rchk(`PFS_OFF_PA_DIR, 8'h3B, 8'h3B);
	bus(1'b1, `PFS_OFF_STEER, 8'h00, 1'b1);
	clkout_en <= 1'b1;
	repeat (4) @(posedge clk);
	chk({7'h00, pa_out[4]}, 8'h00);
	clkout_val <= 1'b1;
	sosc_out_en <= 1'b1;
	repeat (4) @(posedge clk);
	chk({7'h00, pa_out[4]}, 8'h01);
	clkout_en <= 1'b0;
	repeat (4) @(posedge clk);
	chk({7'h00, pa_out[4]}, 8'h00);
	$display("Test steering done");
	pc_ext <= 8'hA5;
	bus(1'b1, `PFS_OFF_PC_ANALOG, 8'h01, 1'b1);
	rchk(`PFS_OFF_PC_LEVEL, 8'hA4, 8'hFF);
	chk(pc_digital_in, 8'hA4);
	bus(1'b1, `PFS_OFF_PC_LEVEL, 8'h00, 1'b0);
	rchk(`PFS_OFF_PC_LATCH, 8'hA4, 8'hFF);
	$display("Test port C done");
	report_and_stop;
end
initial begin
	repeat (5000) @(posedge clk);
	miscompares = miscompares + 1;
	report_and_stop;
end
endmodule // tb_top
